// ==== design/xpd_pkg.sv ====
// Purpose: shared constants and types for the extension-bus enable decoder
// Assumes: 24-bit cpu addresses, AHB-Lite register access with 32-bit data
// Notes:   window table index order matches the enable bit order
package xpd_pkg;

   // ==========================================================
   // register map (byte addresses inside the slave)
   localparam logic [15:0] XPD_OFS_ENABLE = 16'hF024;
   localparam logic [15:0] XPD_OFS_CONFIG = 16'hF028;
   localparam logic [15:0] XPD_OFS_STATUS = 16'hF02C;

   localparam int          XPD_NPER       = 11;
   localparam logic [10:0] XPD_ENABLE_RST = 11'h005;
   localparam logic [10:0] XPD_SHARED_MSK = 11'h7D3;

   // enable bit positions
   localparam int XPD_B_CAN1  = 0;
   localparam int XPD_B_CAN2  = 1;
   localparam int XPD_B_XRAM1 = 2;
   localparam int XPD_B_XRAM2 = 3;
   localparam int XPD_B_RTC   = 4;
   localparam int XPD_B_FLASH = 5;
   localparam int XPD_B_PWM   = 6;
   localparam int XPD_B_ASC   = 7;
   localparam int XPD_B_SSC   = 8;
   localparam int XPD_B_I2C   = 9;
   localparam int XPD_B_MISC  = 10;
   localparam int XPD_W_SHARE = 11;
   localparam int XPD_W_SEG8  = 12;
   localparam int XPD_NWIN    = 13;

   // config and status field positions
   localparam int XPD_CFG_GLOBAL = 0;
   localparam int XPD_ST_LOCK    = 0;
   localparam int XPD_ST_STRAP   = 1;
   localparam int XPD_ST_EMU     = 2;
   localparam int XPD_ST_SEG8    = 4;
   localparam int XPD_ST_EFF     = 16;

   // segment 8 map codes
   localparam logic [1:0] XPD_S8_EXT  = 2'h0;
   localparam logic [1:0] XPD_S8_IFL  = 2'h1;
   localparam logic [1:0] XPD_S8_RSV  = 2'h2;

   // strap capture delay after reset release, covers the synchroniser
   localparam logic [1:0] XPD_STRAP_WAIT = 2'h3;

   // ==========================================================
   // address windows, index = enable bit, then shared window and segment 8
   localparam logic [12:0][23:0] XPD_WIN_LO = {
      24'h080000, 24'h00E800, 24'h00EB00, 24'h00EA00, 24'h00E800,
      24'h00E900, 24'h00EC00, 24'h090000, 24'h00ED00, 24'h0F0000,
      24'h00E000, 24'h00EC00, 24'h00EC00};
   localparam logic [12:0][23:0] XPD_WIN_HI = {
      24'h08FFFF, 24'h00EFFF, 24'h00EBFF, 24'h00EAFF, 24'h00E8FF,
      24'h00E9FF, 24'h00ECFF, 24'h0EFFFF, 24'h00EDFF, 24'h0FFFFF,
      24'h00E7FF, 24'h00EFFF, 24'h00EFFF};

   // ==========================================================
   // carriers
   typedef enum logic [2:0] {
      XPD_RT_NONE,
      XPD_RT_ONCHIP,
      XPD_RT_EXTERNAL,
      XPD_RT_RESERVED,
      XPD_RT_IFLASH
   } xpd_route_t;

   typedef struct packed {
      logic        valid;
      logic [23:0] addr;
   } xpd_cpu_req_t;

   typedef struct packed {
      logic        valid;
      xpd_route_t  route;
      logic [10:0] target;
      logic        emu;
   } xpd_route_res_t;

endpackage

// ==== design/xpd_window.sv ====
// Purpose: inclusive address range compare for one decode window
// Assumes: bounds are constants, lo not above hi
// Notes:   purely combinational, instanced once per window
`timescale 1ns/10ps
module xpd_window #(
   parameter logic [23:0] LO = 24'h000000,
   parameter logic [23:0] HI = 24'h000000
) (
   input  wire logic [23:0] addr,   // cpu address
   output logic             hit     // address inside window
);
   // ==========================================================
   // compare
   assign hit = (addr >= LO) && (addr <= HI);
endmodule

// ==== design/xpd_decoder.sv ====
// Purpose: extension peripheral enable register and cpu address routing
// Assumes: cpu request from the same clock, strap and emulation pins async
// Notes:   route result is registered, one cycle behind the request
//
// Summary of operation
// - first CAN off blocks it, shared fallthrough
// - second CAN off blocks it, shared fallthrough
// - small RAM off routes range external
// - large RAM off, external only if flash off
// - clock module off blocks it, shared fallthrough
// - extension PWM off blocks it, shared fallthrough
// - flash off, external only if large RAM off
// - async serial off blocks it, shared fallthrough
// - sync serial off blocks it, shared fallthrough
// - two-wire off blocks it, shared fallthrough
// - misc features off blocks them, shared fallthrough
// - all shared disabled sends window external
// - disabled peripheral pins released to gpio
// - reset enables first CAN and small RAM
// - enable register frozen after global enable
// - emulation forces every enable on
// - segment 8 from strap, global, RAM, flash
`timescale 1ns/10ps
module xpd_decoder
   import xpd_pkg::*;
(
   input  wire logic             hclk,             // system clock
   input  wire logic             hresetn,          // async reset, active low
   input  wire logic             hsel,             // slave select
   input  wire logic [31:0]      haddr,            // byte address
   input  wire logic [1:0]       htrans,           // transfer type
   input  wire logic             hwrite,           // write when high
   input  wire logic [2:0]       hsize,            // transfer size
   input  wire logic [31:0]      hwdata,           // write data
   input  wire logic             hready,           // bus ready
   output logic                  hreadyout,        // slave ready
   output logic                  hresp,            // always okay
   output logic [31:0]           hrdata,           // read data
   input  wire xpd_pkg::xpd_cpu_req_t   cpu_req,   // cpu access
   output xpd_pkg::xpd_route_res_t      route,     // routing decision
   input  wire logic             ext_access_pin,   // external access strap
   input  wire logic             emulation_pin,    // emulation mode level
   output logic [10:0]           periph_enable,    // effective enables
   output logic [10:0]           gpio_release      // pins free for gpio
);
   import xpd_pkg::*;

   // ==========================================================
   // state
   logic [10:0]    enable_q;
   logic           global_q;
   logic           ea_s1_q, ea_s2_q, emu_s1_q, emu_s2_q;
   logic           strap_q, strap_done_q;
   logic [1:0]     strap_cnt_q;
   logic           wr_pend_q, rd_pend_q;
   logic [15:0]    bus_addr_q;
   logic           hreadyout_q;
   logic [31:0]    hrdata_q;
   xpd_route_res_t route_q;
   logic [10:0]    periph_enable_q, gpio_release_q;
   logic           rst_seen_q;

   // ==========================================================
   // bus decode
   wire         addr_phase = hsel && htrans[1] && hready;
   wire [15:0]  phase_addr = haddr[15:0];
   wire         sel_enable = (bus_addr_q == XPD_OFS_ENABLE);
   wire         sel_config = (bus_addr_q == XPD_OFS_CONFIG);
   wire         sel_status = (bus_addr_q == XPD_OFS_STATUS);

   // ==========================================================
   // effective enables and window hits
   logic [12:0] hit;
   wire [10:0] en        = emu_s2_q ? {XPD_NPER{1'b1}} : enable_q;
   wire        shared_on = |(en & XPD_SHARED_MSK);

   genvar gi;
   generate
      for (gi = 0; gi < XPD_NWIN; gi++) begin : g_win
         xpd_window #(
            .LO (XPD_WIN_LO[gi]),
            .HI (XPD_WIN_HI[gi])
         ) u_win (
            .addr (cpu_req.addr),
            .hit  (hit[gi])
         );
      end
   endgenerate

   // ==========================================================
   // segment 8 map
   // strap global memories
   wire [1:0] seg8_map = strap_q   ? XPD_S8_IFL :
                         !global_q ? XPD_S8_EXT :
                         (!en[XPD_B_XRAM2] && !en[XPD_B_FLASH]) ? XPD_S8_EXT :
                         XPD_S8_RSV;

   // ==========================================================
   // route decision, same cycle as the address
   // combinational decode
   xpd_route_t rt;
   always_comb begin
      rt = XPD_RT_NONE;
      if (hit[XPD_B_XRAM1]) begin
         rt = en[XPD_B_XRAM1] ? XPD_RT_ONCHIP : XPD_RT_EXTERNAL;
      end else if (hit[XPD_W_SHARE]) begin
         rt = shared_on ? XPD_RT_ONCHIP : XPD_RT_EXTERNAL;
      end else if (hit[XPD_B_XRAM2] || hit[XPD_B_FLASH]) begin
         if ((hit[XPD_B_XRAM2] && en[XPD_B_XRAM2]) ||
             (hit[XPD_B_FLASH] && en[XPD_B_FLASH])) begin
            rt = XPD_RT_ONCHIP;
         end else if (!en[XPD_B_XRAM2] && !en[XPD_B_FLASH]) begin
            rt = XPD_RT_EXTERNAL;
         end else begin
            rt = XPD_RT_RESERVED;
         end
      end else if (hit[XPD_W_SEG8]) begin
         case (seg8_map)
            XPD_S8_IFL: rt = XPD_RT_IFLASH;
            XPD_S8_EXT: rt = XPD_RT_EXTERNAL;
            default:    rt = XPD_RT_RESERVED;
         endcase
      end
   end

   wire [10:0] target = (rt == XPD_RT_ONCHIP) ? (hit[10:0] & en) : 11'h000;

   // ==========================================================
   // pin synchronisers, first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ea_s1_q  <= 1'b0;
         ea_s2_q  <= 1'b0;
         emu_s1_q <= 1'b0;
         emu_s2_q <= 1'b0;
      end else begin
         ea_s1_q  <= ext_access_pin;
         ea_s2_q  <= ea_s1_q;
         emu_s1_q <= emulation_pin;
         emu_s2_q <= emu_s1_q;
      end
   end

   // strap caught once after release, once the synchroniser is full
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_cnt_q  <= 2'h0;
         strap_done_q <= 1'b0;
         strap_q      <= 1'b0;
      end else if (!strap_done_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == XPD_STRAP_WAIT) begin
            strap_done_q <= 1'b1;
            strap_q      <= ea_s2_q;
         end
      end
   end

   // ==========================================================
   // bus phases: writes zero wait, reads one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q   <= 1'b0;
         rd_pend_q   <= 1'b0;
         bus_addr_q  <= 16'h0000;
         hreadyout_q <= 1'b1;
      end else begin
         wr_pend_q   <= addr_phase && hwrite;
         rd_pend_q   <= addr_phase && !hwrite;
         hreadyout_q <= !(addr_phase && !hwrite);
         if (addr_phase) begin
            bus_addr_q <= phase_addr;
         end
      end
   end

   // read mux, reserved bits read zero, unmapped reads zero
   wire [31:0] status_word = ({21'h000000, en} << XPD_ST_EFF)
                           | ({30'h00000000, seg8_map} << XPD_ST_SEG8)
                           | ({31'h00000000, emu_s2_q} << XPD_ST_EMU)
                           | ({31'h00000000, strap_q} << XPD_ST_STRAP)
                           | ({31'h00000000, global_q} << XPD_ST_LOCK);
   wire [31:0] rd_word = sel_enable ? {21'h000000, enable_q} :
                         sel_config ? ({31'h00000000, global_q} << XPD_CFG_GLOBAL) :
                         sel_status ? status_word : 32'h00000000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (rd_pend_q) begin
         hrdata_q <= rd_word;
      end
   end

   // ==========================================================
   // enable register and global enable
   // global enable is set only; clearing needs a reset, which keeps the lock honest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_q <= XPD_ENABLE_RST;
         global_q <= 1'b0;
      end else if (wr_pend_q) begin
         if (sel_enable && !global_q) begin
            enable_q <= hwdata[10:0];
         end
         if (sel_config && hwdata[XPD_CFG_GLOBAL]) begin
            global_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         route_q         <= '{valid: 1'b0, route: XPD_RT_NONE, target: 11'h000, emu: 1'b0};
         periph_enable_q <= XPD_ENABLE_RST;
         gpio_release_q  <= ~XPD_ENABLE_RST;
         rst_seen_q      <= 1'b0;
      end else begin
         route_q.valid   <= cpu_req.valid;
         route_q.route   <= cpu_req.valid ? rt : XPD_RT_NONE;
         route_q.target  <= cpu_req.valid ? target : 11'h000;
         route_q.emu     <= emu_s2_q;
         periph_enable_q <= en;
         gpio_release_q  <= ~en;
         rst_seen_q      <= 1'b1;
      end
   end

   assign hreadyout     = hreadyout_q;
   assign hresp         = 1'b0;
   assign hrdata        = hrdata_q;
   assign route         = route_q;
   assign periph_enable = periph_enable_q;
   assign gpio_release  = gpio_release_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_rd_addr;
      addr_phase && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_wr_locked;
      addr_phase && hwrite && (phase_addr == XPD_OFS_ENABLE) && global_q;
   endsequence

   chk_reset_default: assert property (
      !rst_seen_q |-> (enable_q == XPD_ENABLE_RST) && !global_q)
      else $error("enable register not at reset default");
   chk_lock_hold: assert property (
      s_wr_locked |=> ##1 $stable(enable_q))
      else $error("enable register changed while locked");
   chk_small_ram: assert property (
      cpu_req.valid && hit[XPD_B_XRAM1] && !en[XPD_B_XRAM1]
      |=> route_q.route == XPD_RT_EXTERNAL)
      else $error("small ram range not external when off");
   chk_shared_ext: assert property (
      cpu_req.valid && hit[XPD_W_SHARE] && !shared_on
      |=> route_q.route == XPD_RT_EXTERNAL && route_q.target == 11'h000)
      else $error("shared window not external when all off");
   chk_memory_reserved: assert property (
      cpu_req.valid && hit[XPD_B_XRAM2] && !en[XPD_B_XRAM2] && en[XPD_B_FLASH]
      |=> route_q.route == XPD_RT_RESERVED)
      else $error("large ram range not reserved with flash on");
   chk_flash_external: assert property (
      cpu_req.valid && hit[XPD_B_FLASH] && !en[XPD_B_FLASH] && !en[XPD_B_XRAM2]
      |=> route_q.route == XPD_RT_EXTERNAL)
      else $error("flash range not external with both off");
   chk_block_off: assert property (
      cpu_req.valid |=> (route_q.target & ~$past(en)) == 11'h000)
      else $error("disabled peripheral was targeted");
   chk_gpio_release: assert property (
      gpio_release_q == ~periph_enable_q)
      else $error("gpio release differs from enables");
   chk_emu_all_on: assert property (
      emu_s2_q |=> periph_enable_q == 11'h7FF)
      else $error("emulation did not force enables on");
   chk_seg8_map: assert property (
      cpu_req.valid && hit[XPD_W_SEG8] && !strap_q && !global_q
      |=> route_q.route == XPD_RT_EXTERNAL)
      else $error("segment 8 not external without global enable");
   chk_route_next: assert property (
      cpu_req.valid |=> route_q.valid)
      else $error("route not presented one cycle after request");
   chk_read_wait: assert property (
      s_rd_addr |=> s_rd_answer)
      else $error("read answer not after one wait state");

endmodule

// ==== sim/xpd_cpu_model.sv ====
// Purpose: cpu core stand-in that presents one address per call
// Assumes: decoder samples cpu_req on every rising edge
// Notes:   after the sampled cycle the address is inverted, never held
`timescale 1ns/10ps
module xpd_cpu_model
   import xpd_pkg::*;
(
   input  wire logic            hclk,     // system clock
   output xpd_pkg::xpd_cpu_req_t cpu_req  // access to the decoder
);
   import xpd_pkg::*;

   // ==========================================================
   // request driver
   initial cpu_req = '0;

   // one valid cycle, then a changed idle address so stale values never match
   task automatic issue(input logic [23:0] a);
      @(posedge hclk);
      cpu_req <= {1'b1, a};
      @(posedge hclk);
      cpu_req <= {1'b0, ~a};
   endtask
endmodule

// ==== sim/xpd_decoder_tb.sv ====
// Purpose: self-checking bench for the enable register and cpu routing
// Assumes: one-wait reads, zero-wait writes, route one cycle after request
// Notes:   every wait is bounded; a run-out ends the run as a failure
`timescale 1ns/10ps
module xpd_decoder_tb;
   import xpd_pkg::*;

   // ==========================================================
   // clock, reset and bus signals
   logic                  hclk = 1'b0;
   logic                  hresetn = 1'b0;
   logic                  hsel = 1'b0;
   logic [31:0]           haddr = '0;
   logic [1:0]            htrans = 2'h0;
   logic                  hwrite = 1'b0;
   logic [31:0]           hwdata = '0;
   logic                  hreadyout;
   logic                  hresp;
   logic [31:0]           hrdata;
   xpd_cpu_req_t          cpu_req;
   xpd_route_res_t        route;
   logic                  ext_access_pin = 1'b0;
   logic                  emulation_pin = 1'b0;
   logic [10:0]           periph_enable;
   logic [10:0]           gpio_release;
   logic [31:0]           rd;
   int                    err_count = 0;
   int                    checks_done = 0;

   always #2.5 hclk = ~hclk;

   // ==========================================================
   // design and cpu stand-in
   xpd_decoder xpd_decoder_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_req(cpu_req),
      .route(route), .ext_access_pin(ext_access_pin), .emulation_pin(emulation_pin),
      .periph_enable(periph_enable), .gpio_release(gpio_release));
   xpd_cpu_model xpd_cpu_model_inst (.hclk(hclk), .cpu_req(cpu_req));

   // ==========================================================
   // verdict and comparisons
   task automatic complete_run();
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask

   // route result sampled once its edge has landed
   task automatic chk_route(input logic [23:0] a, input xpd_route_t rt,
                            input logic [10:0] tgt, input logic emu);
      xpd_cpu_model_inst.issue(a);
      #1;
      chk({16'h0, route}, {16'h0, 1'b1, rt, tgt, emu});
      // back onto a rising edge so the next stimulus lands there
      @(posedge hclk);
   endtask

   // ==========================================================
   // bus master, one aligned word per transfer
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         complete_run();
      end
   endtask

   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {16'h0, a};
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   // reserved upper bits always written as zero
   task automatic wr_en(input logic [10:0] v);
      bus(1'b1, XPD_OFS_ENABLE, {21'h0, v});
   endtask

   task automatic do_reset(input logic strap);
      hresetn        <= 1'b0;
      ext_access_pin <= strap;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
   endtask

   // ==========================================================
   // scenarios
   task automatic s_reset_values();
      bus(1'b0, XPD_OFS_ENABLE, '0);
      chk(rd, 32'h0000_0005);
      chk({21'h0, periph_enable}, 32'h0000_0005);
      chk({21'h0, gpio_release}, 32'h0000_07FA);
      chk({31'h0, hresp}, 32'h0);
      chk_route(24'h00E000, XPD_RT_ONCHIP, 11'h004, 1'b0);
      chk_route(24'h00E850, XPD_RT_ONCHIP, 11'h000, 1'b0);
      chk_route(24'h001000, XPD_RT_NONE, 11'h000, 1'b0);
      bus(1'b0, 16'hF030, '0);
      chk(rd, 32'h0);
   endtask

   // each shared peripheral alone, window routed to it only
   task automatic s_shared_each();
      int          sb[8] = '{0, 1, 4, 6, 7, 8, 9, 10};
      logic [23:0] sa[8] = '{24'h00EE00, 24'h00EE00, 24'h00ED00, 24'h00EC00,
                             24'h00E900, 24'h00E800, 24'h00EA00, 24'h00EB00};
      logic [10:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 11'h001 << sb[i];
         wr_en(m);
         bus(1'b0, XPD_OFS_ENABLE, '0);
         chk(rd, {21'h0, m});
         chk({21'h0, gpio_release}, {21'h0, ~m});
         chk_route(sa[i], XPD_RT_ONCHIP, m, 1'b0);
      end
      chk_route(24'h00E000, XPD_RT_EXTERNAL, 11'h000, 1'b0);
   endtask

   task automatic s_all_off();
      wr_en(11'h000);
      chk_route(24'h00EC00, XPD_RT_EXTERNAL, 11'h000, 1'b0);
      chk_route(24'h00E9FF, XPD_RT_EXTERNAL, 11'h000, 1'b0);
      chk_route(24'h0F0000, XPD_RT_EXTERNAL, 11'h000, 1'b0);
      chk_route(24'h0EFFFF, XPD_RT_EXTERNAL, 11'h000, 1'b0);
      wr_en(11'h008);
      chk_route(24'h0FFFFF, XPD_RT_ONCHIP, 11'h008, 1'b0);
      chk_route(24'h090000, XPD_RT_RESERVED, 11'h000, 1'b0);
      chk_route(24'h080000, XPD_RT_EXTERNAL, 11'h000, 1'b0);
      wr_en(11'h020);
      chk_route(24'h090000, XPD_RT_ONCHIP, 11'h020, 1'b0);
      chk_route(24'h0F0000, XPD_RT_RESERVED, 11'h000, 1'b0);
   endtask

   // lock, then try to change the enables
   task automatic s_lock(input logic [10:0] v, input xpd_route_t s8r,
                         input logic [1:0] s8c);
      wr_en(v);
      bus(1'b1, XPD_OFS_CONFIG, 32'h1);
      wr_en(~v);
      bus(1'b0, XPD_OFS_ENABLE, '0);
      chk(rd, {21'h0, v});
      chk_route(24'h08ABCD, s8r, 11'h000, 1'b0);
      bus(1'b0, XPD_OFS_STATUS, '0);
      chk({30'h0, rd[5:4]}, {30'h0, s8c});
      chk(rd, {5'h0, v, 10'h0, s8c, 4'h1});
      bus(1'b0, XPD_OFS_CONFIG, '0);
      chk(rd, 32'h0000_0001);
   endtask

   task automatic s_emulation();
      emulation_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({21'h0, periph_enable}, 32'h0000_07FF);
      chk_route(24'h00E000, XPD_RT_ONCHIP, 11'h004, 1'b1);
      bus(1'b0, XPD_OFS_STATUS, '0);
      chk(rd, {5'h0, 11'h7FF, 10'h0, XPD_S8_IFL, 4'h6});
   endtask

   // ==========================================================
   // main sequence and hang guard
   initial begin
      do_reset(1'b0);
      s_reset_values();
      s_shared_each();
      s_all_off();
      s_lock(11'h008, XPD_RT_RESERVED, XPD_S8_RSV);
      do_reset(1'b0);
      s_lock(11'h000, XPD_RT_EXTERNAL, XPD_S8_EXT);
      do_reset(1'b1);
      chk_route(24'h080000, XPD_RT_IFLASH, 11'h000, 1'b0);
      s_emulation();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      complete_run();
   end
endmodule
